/* File: spi_reg_target.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Sample on rising clock, shift on falling.
// - Select high: ignore clock and host data.
// - Select falling starts a command sequence.
// - Select rising clears counter and command state.
// - Echo address bits on device output.
// - Abort on deselect; registers untouched.
// - Clock pauses of any length are harmless.
// - Every clock moves one bit each way.
// - Host sends data only for writes.
// - Read data driven only in reads.
// - Writable registers readable; read-only status provided.
// - Unused locations read as zero.
// - Vendor locations may read anything.
// - Writes to unused locations are discarded.
// - Host ends by stopping clock, deselecting.
// - Write starts with 1, address, data, MSB first.
// - Read starts with 0; data follows next fall.
// - Fifteen-bit address, eight-bit data.
// - Address increments after each byte.
module spi_reg_target #(
   parameter int NREGS = spi_port_pkg::RO_BASE
) (
   spi_link_if.device link,
   input  wire logic  sysClk,
   input  wire logic  sysRst,
   output var  logic  [7:0] reg0Out
);
   // Register file lives in the link domain; clocked only by the host
   localparam int AW = spi_port_pkg::ADDR_BITS;
   localparam int DW = spi_port_pkg::DATA_BITS;
   localparam int CW = spi_port_pkg::CMD_BITS;

   // Writable locations must stop short of the read-only status ones
   if (NREGS < 1 || NREGS > spi_port_pkg::RO_BASE)
   begin
      $error("NREGS out of range");
   end

   logic [4:0]    bitCnt_r;     // Bits seen in header (0..CW)
   logic [4:0]    bitCnt_nxt;
   logic [2:0]    dataCnt_r;    // Bit index inside current data byte
   logic [2:0]    dataCnt_nxt;
   logic          isWrite_r;    // Direction of this frame
   logic          isWrite_nxt;
   logic [AW-1:0] addr_r;       // Current register address
   logic [AW-1:0] addr_nxt;
   logic [DW-1:0] shIn_r;       // Incoming data byte
   logic [DW-1:0] shIn_nxt;
   logic [DW-1:0] regs_r [NREGS];// Writable registers
   logic [DW-1:0] rdByte_r;     // Byte being shifted out
   logic          outBit_r;     // Bit on the device output
   logic          wrEn;         // Commit strobe of a full write byte
   logic [AW-1:0] wrAddr;       // Location that a full write byte lands in
   logic [DW-1:0] rdFetch;      // Register under the current address
   logic [DW-1:0] rdByte_nxt;
   logic          outBit_nxt;
   logic [DW-1:0] reg0Sync;     // Register zero after two flops, may be torn
   logic [DW-1:0] reg0Seen_r;   // Previous synchronised sample
   logic [DW-1:0] reg0Seen_nxt;
   logic [DW-1:0] reg0Out_nxt;

   // Read mux: writable, then read-only status, zero elsewhere
   function automatic logic [DW-1:0] readReg(input logic [AW-1:0] a);
      logic [DW-1:0] v;
      v = spi_port_pkg::UNUSED_READ;
      if (a < AW'(NREGS))
         v = regs_r[a[$clog2(NREGS+1)-1:0]];
      else if (a == AW'(spi_port_pkg::RO_BASE))
         v = spi_port_pkg::REVISION;
      else if (a == AW'(spi_port_pkg::RO_BASE + 1))
         v = spi_port_pkg::STATUS_ID;
      return v;
   endfunction

   // Receive side next state; one host bit per rising edge
   always_comb
   begin
      bitCnt_nxt  = bitCnt_r;
      dataCnt_nxt = dataCnt_r;
      isWrite_nxt = isWrite_r;
      addr_nxt    = addr_r;
      shIn_nxt    = shIn_r;
      wrEn        = 1'b0;
      wrAddr      = addr_r;
      if (bitCnt_r == 5'd0)
      begin
         isWrite_nxt = (link.hostData == spi_port_pkg::DIR_WRITE);
         bitCnt_nxt  = 5'd1;
      end
      else if (bitCnt_r < 5'(CW))
      begin
         addr_nxt   = {addr_r[AW-2:0], link.hostData};
         bitCnt_nxt = bitCnt_r + 5'd1;
      end
      else
      begin
         shIn_nxt    = {shIn_r[DW-2:0], link.hostData};
         dataCnt_nxt = dataCnt_r + 3'd1;
         if (dataCnt_r == 3'd7)
         begin
            wrEn     = isWrite_r;
            addr_nxt = addr_r + AW'(1);
         end
      end
   end

   // Header state; select high holds everything in reset
   always_ff @(posedge link.sclk or posedge link.selN)
   begin
      if (link.selN)
      begin
         bitCnt_r  <= 5'd0;
         dataCnt_r <= 3'd0;
         isWrite_r <= 1'b0;
         addr_r    <= '0;
         shIn_r    <= '0;
      end
      else
      begin
         bitCnt_r  <= bitCnt_nxt;
         dataCnt_r <= dataCnt_nxt;
         isWrite_r <= isWrite_nxt;
         addr_r    <= addr_nxt;
         shIn_r    <= shIn_nxt;
      end
   end

   // Register commit; an aborted byte never reaches here
   always_ff @(posedge link.sclk or posedge sysRst)
   begin
      if (sysRst)
      begin
         for (int i = 0; i < NREGS; i++)
            regs_r[i] <= spi_port_pkg::REG_RESET;
      end
      else if (wrEn && !link.selN && wrAddr < AW'(NREGS))
         regs_r[wrAddr[$clog2(NREGS+1)-1:0]] <= {shIn_r[DW-2:0], link.hostData};
   end

   // Transmit side next values; the fetch is made at the byte boundary,
   // so a byte written just before is already seen by a following read
   always_comb
   begin
      rdFetch    = readReg(addr_r);
      rdByte_nxt = rdByte_r;
      outBit_nxt = 1'b0;
      if (bitCnt_r >= 5'd1 && bitCnt_r < 5'(CW))
         outBit_nxt = addr_r[0];
      else if (bitCnt_r == 5'(CW))
      begin
         if (dataCnt_r == 3'd0)
         begin
            // Fetch at byte boundary, first bit out now
            rdByte_nxt = rdFetch << 1;
            outBit_nxt = isWrite_r ? 1'b0 : rdFetch[DW-1];
         end
         else
         begin
            // Later bits of the byte come from the shifter
            rdByte_nxt = rdByte_r << 1;
            outBit_nxt = isWrite_r ? 1'b0 : rdByte_r[DW-1];
         end
      end
   end

   // Transmit registers: change output on falling edge; select high presets it high
   always_ff @(negedge link.sclk or posedge link.selN)
   begin
      if (link.selN)
      begin
         outBit_r <= 1'b1;
         rdByte_r <= '0;
      end
      else
      begin
         outBit_r <= outBit_nxt;
         rdByte_r <= rdByte_nxt;
      end
   end

   assign link.devData   = outBit_r;
   assign link.devDataOe = link.selN;

   // Register zero seen in system domain through a synchroniser
   spi_sync2 #(.WIDTH(8), .INIT(1'b0)) uReg0Sync (
      .clk  (sysClk),
      .rst  (sysRst),
      .din  (regs_r[0]),
      .dout (reg0Sync)
   );

   // A byte is taken only once two samples agree; a word caught in the
   // middle of a change never shows. Writes come bytes apart, so this holds.
   always_comb
   begin
      reg0Seen_nxt = reg0Sync;
      reg0Out_nxt  = reg0Out;
      if (reg0Sync == reg0Seen_r)
         reg0Out_nxt = reg0Sync;
   end

   // System side registers only
   always_ff @(posedge sysClk or posedge sysRst)
   begin
      if (sysRst)
      begin
         reg0Seen_r <= spi_port_pkg::REG_RESET;
         reg0Out    <= spi_port_pkg::REG_RESET;
      end
      else
      begin
         reg0Seen_r <= reg0Seen_nxt;
         reg0Out    <= reg0Out_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: spi_port_pkg.sv */
`default_nettype none
package spi_port_pkg;
   // Frame layout: one direction bit, a 15-bit address, then data bytes
   localparam int ADDR_BITS = 15;             // Register address width
   localparam int DATA_BITS = 8;              // Register data width
   localparam int CMD_BITS  = 1 + ADDR_BITS;  // Direction bit plus address
   localparam logic DIR_WRITE = 1'h1;         // First host bit of a write
   localparam logic DIR_READ  = 1'h0;         // First host bit of a read
   localparam logic [7:0] UNUSED_READ = 8'h00; // Answer from an unused location
   localparam int NUM_REGS = 16;              // Implemented register locations
   localparam int RO_BASE  = 14;              // First read-only location
   localparam logic [7:0] REG_RESET = 8'h00;  // Value of writable registers after reset
   localparam logic [7:0] REVISION  = 8'h11;  // Revision code, arbitrary value
   localparam logic [7:0] STATUS_ID = 8'h5a;  // Status code, arbitrary value
   localparam int CLK_DIV_HALF = 8;           // System cycles per half link clock
endpackage
`default_nettype wire

/* File: spi_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Four-wire serial link between the host and the register port
interface spi_link_if;
   logic selN;      // Active-low select from the host
   logic sclk;      // Serial clock from the host, idles high
   logic hostData;  // Host to device data
   logic devData;   // Device to host data
   logic devDataOe; // Low while the device drives devData
   logic misoWire;  // Resolved line level seen by the host

   // Released line floats; the pull keeps it high
   assign misoWire = devDataOe ? 1'b1 : devData;

   modport device (input selN, input sclk, input hostData, output devData, output devDataOe);
   modport host   (output selN, output sclk, output hostData, input misoWire);
endinterface
`default_nettype wire

/* File: spi_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for levels crossing into a clock domain
module spi_sync2 #(
   parameter int        WIDTH = 1,
   parameter logic      INIT  = 1'b0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r; // First stage, read only by second stage

   // A zero-width synchroniser has nothing to carry
   if (WIDTH < 1)
   begin
      $error("WIDTH must be at least one");
   end

   // Plain two-stage shift; reset to the idle level
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= {WIDTH{INIT}};
         dout   <= {WIDTH{INIT}};
      end
      else
      begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: spi_host_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Host end: runs one register access per request, clock from a divider
module spi_host_ctrl (
   spi_link_if.host    link,
   input  wire logic          clk_sys,
   input  wire logic          sys_rst,
   input  wire logic          reqValid,
   output logic               reqReady,
   input  wire logic          reqWrite,
   input  wire logic [14:0]   reqAddr,
   input  wire logic [7:0]    reqData,
   output logic               rspValid,
   output logic [7:0]         rspData
);
   localparam int FRAME_BITS = spi_port_pkg::CMD_BITS + spi_port_pkg::DATA_BITS;
   localparam int HALF_LAST  = spi_port_pkg::CLK_DIV_HALF - 1;

   typedef enum logic [1:0] {IDLE, SHIFT, DONE} hstate_t;

   hstate_t     st_r;       // Sequencer state
   hstate_t     st_nxt;
   logic [4:0]  half_r;     // System cycles into this half period
   logic [4:0]  half_nxt;
   logic [5:0]  bits_r;     // Falling edges still to come
   logic [5:0]  bits_nxt;
   logic [23:0] tx_r;       // Outgoing frame, top bit on the line
   logic [23:0] tx_nxt;
   logic [7:0]  rx_r;       // Last eight bits taken from the device
   logic [7:0]  rx_nxt;
   logic        sclk_r;     // Link clock, idles high
   logic        sclk_nxt;
   logic        selN_r;     // Select, active low
   logic        selN_nxt;
   logic        rv_r;       // Response strobe
   logic        rv_nxt;
   logic [7:0]  rd_r;       // Held read data
   logic [7:0]  rd_nxt;
   logic        misoS;      // Synchronised device output

   // The divider counter is five bits wide
   if (spi_port_pkg::CLK_DIV_HALF < 1 || spi_port_pkg::CLK_DIV_HALF > 32)
   begin
      $error("CLK_DIV_HALF out of range");
   end

   // Device output comes from the link domain; two flops before use
   spi_sync2 #(.WIDTH(1), .INIT(1'b1)) uMisoSync (
      .clk  (clk_sys),
      .rst  (sys_rst),
      .din  (link.misoWire),
      .dout (misoS)
   );

   // Sequencer: the first falling edge finds the direction bit already on
   // the line; later falling edges move on a bit, rising edges sample
   always_comb
   begin
      st_nxt   = st_r;
      half_nxt = half_r;
      bits_nxt = bits_r;
      tx_nxt   = tx_r;
      rx_nxt   = rx_r;
      sclk_nxt = sclk_r;
      selN_nxt = selN_r;
      rv_nxt   = 1'b0;
      rd_nxt   = rd_r;
      case (st_r)
         IDLE:
         begin
            if (reqValid)
            begin
               // Reads carry no data bits from the host
               tx_nxt   = {reqWrite, reqAddr, reqWrite ? reqData : 8'h00};
               bits_nxt = 6'(FRAME_BITS);
               selN_nxt = 1'b0;
               half_nxt = 5'd0;
               st_nxt   = SHIFT;
            end
         end
         SHIFT:
         begin
            if (half_r == 5'(HALF_LAST))
            begin
               half_nxt = 5'd0;
               sclk_nxt = ~sclk_r;
               if (sclk_r)
               begin
                  // Falling edge: next bit out, the first one stands already
                  bits_nxt = bits_r - 6'd1;
                  if (bits_r != 6'(FRAME_BITS))
                     tx_nxt = {tx_r[22:0], 1'b0};
               end
               else
               begin
                  // Rising edge: device bit has stood for a half period
                  rx_nxt = {rx_r[6:0], misoS};
                  if (bits_r == 6'd0)
                     st_nxt = DONE;
               end
            end
            else
               half_nxt = half_r + 5'd1;
         end
         DONE:
         begin
            // Clock already high; deselect ends the frame
            selN_nxt = 1'b1;
            rv_nxt   = 1'b1;
            rd_nxt   = rx_r;
            st_nxt   = IDLE;
         end
         default:
            st_nxt = IDLE;
      endcase
   end

   // Registers only; reset leaves the link idle and deselected
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r   <= IDLE;
         half_r <= 5'd0;
         bits_r <= 6'd0;
         tx_r   <= '0;
         rx_r   <= '0;
         sclk_r <= 1'b1;
         selN_r <= 1'b1;
         rv_r   <= 1'b0;
         rd_r   <= '0;
      end
      else
      begin
         st_r   <= st_nxt;
         half_r <= half_nxt;
         bits_r <= bits_nxt;
         tx_r   <= tx_nxt;
         rx_r   <= rx_nxt;
         sclk_r <= sclk_nxt;
         selN_r <= selN_nxt;
         rv_r   <= rv_nxt;
         rd_r   <= rd_nxt;
      end
   end

   assign reqReady      = (st_r == IDLE);
   assign rspValid      = rv_r;
   assign rspData       = rd_r;
   assign link.sclk     = sclk_r;
   assign link.selN     = selN_r;
   assign link.hostData = tx_r[23];
endmodule
`default_nettype wire

/* File: spi_link_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the host-to-target link on the system clock
module spi_link_checker (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic selN,
   input wire logic sclk,
   input wire logic hostData,
   input wire logic devData,
   input wire logic devDataOe,
   input wire logic misoWire
);
   logic [4:0] bits_r;    // Rising link edges in this frame
   logic [4:0] bits_nxt;  // Next edge count
   logic       prev_r;    // Host bit taken at the last rise
   logic       prev_nxt;  // Next remembered bit
   logic       sclkQ_r;   // Link clock at the last sample
   logic       selQ_r;    // Select at the last sample
   logic       rise;      // Link clock rose since the last sample

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // Count from the select fall so a late deselect still sees the last rise
   always_comb
   begin
      rise = sclk && !sclkQ_r;
      bits_nxt = (selQ_r && !selN) ? 5'h00 : bits_r + {4'h0, rise};
      prev_nxt = rise ? hostData : prev_r;
   end

   // Registers only
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bits_r <= 5'h00;
         prev_r <= 1'b0;
         sclkQ_r <= 1'b1;
         selQ_r <= 1'b1;
      end
      else
      begin
         bits_r <= bits_nxt;
         prev_r <= prev_nxt;
         sclkQ_r <= sclk;
         selQ_r <= selN;
      end
   end

   AST_QUIET: assert property (selN |-> devDataOe)
      else $error("device drives data while deselected");
   AST_IDLE: assert property (selN |-> sclk)
      else $error("link clock low outside a frame");
   AST_HALF: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 sclk)
      else $error("link clock low phase has wrong length");
   AST_START: assert property ($fell(selN) |-> sclk ##[1:16] !sclk)
      else $error("frame start not followed by clocking");
   AST_FRAME: assert property ($rose(selN) |-> ##1 bits_r == 5'h18)
      else $error("frame does not hold 24 bits");
   AST_ECHO: assert property (rise && !selN && bits_r inside {[2:15]} |-> misoWire == prev_r)
      else $error("address bit not echoed");
   AST_MOSI: assert property (!selN && $past(!selN) && $changed(hostData) |-> !sclk)
      else $error("host data moved while clock high");
   AST_MISO: assert property (!selN && $past(!selN) && $changed(devData) |-> !sclk)
      else $error("device data moved while clock high");
endmodule
`default_nettype wire

/* File: spi_target_register_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
// Host end and target joined; a second target is driven by hand for faults
module spi_target_register_port_test;
   logic        clk_sys;       // System clock
   logic        sys_rst;       // Reset, active high
   logic        reqValid;      // Request strobe
   logic        reqReady;      // Host can take a request
   logic        reqWrite;      // Request is a write
   logic [14:0] reqAddr;       // Request address
   logic [7:0]  reqData;       // Write data
   logic        rspValid;      // Response pulse
   logic [7:0]  rspData;       // Read data
   logic [7:0]  reg0A;         // Register 0 of the paired target
   logic [7:0]  reg0B;         // Register 0 of the hand-driven target
   logic [7:0]  mem [0:13];    // Expected writable contents
   logic [7:0]  q;             // Last read
   logic [14:0] a;             // Address under test
   logic [39:0] got;           // Bits captured on the second link
   int          i;             // Loop index
   int          miscompares;   // Mismatch count
   int          n_checks;      // Comparison count

   spi_link_if link_a();
   spi_link_if link_b();
   spi_host_ctrl spi_host_ctrl_inst (.link(link_a.host), .clk_sys(clk_sys),
      .sys_rst(sys_rst), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspData(rspData));
   spi_reg_target spi_reg_target_inst (.link(link_a.device), .sysClk(clk_sys),
      .sysRst(sys_rst), .reg0Out(reg0A));
   spi_reg_target spi_reg_target_inst2 (.link(link_b.device), .sysClk(clk_sys),
      .sysRst(sys_rst), .reg0Out(reg0B));
   spi_link_checker spi_link_checker_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .selN(link_a.selN), .sclk(link_a.sclk), .hostData(link_a.hostData),
      .devData(link_a.devData), .devDataOe(link_a.devDataOe), .misoWire(link_a.misoWire));

   always #20 clk_sys = ~clk_sys;

   // Expected read value for any address
   function automatic logic [7:0] expRead(input logic [14:0] ad);
      if (ad < 15'h000e)
         return mem[ad];
      if (ad == 15'h000e)
         return spi_port_pkg::REVISION;
      if (ad == 15'h000f)
         return spi_port_pkg::STATUS_ID;
      return spi_port_pkg::UNUSED_READ;
   endfunction

   task final_report;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One access through the host; every wait is bounded
   task hostAcc(input logic w, input logic [14:0] ad, input logic [7:0] d,
                output logic [7:0] rd);
      int k;
      reqValid <= 1'b1;
      reqWrite <= w;
      reqAddr <= ad;
      reqData <= d;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (reqReady !== 1'b1 && k < 100);
      reqValid <= 1'b0;
      if (reqReady !== 1'b1)
      begin
         miscompares++;
         final_report;
      end
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (rspValid !== 1'b1 && k < 1000);
      rd = rspData;
      if (rspValid !== 1'b1)
      begin
         miscompares++;
         final_report;
      end
   endtask

   // Hand-driven frame on the second link at a 160 ns clock; short n aborts
   task bang(input logic [39:0] bits, input int n, input int pause, input logic sel,
             output logic [39:0] cap);
      int k;
      cap = 40'h0;
      #7 link_b.selN <= sel;
      #80;
      for (k = 0; k < n; k++)
      begin
         if (k == 12)
            #(pause);
         link_b.sclk <= 1'b0;
         link_b.hostData <= bits[39-k];
         #80;
         cap = {cap[38:0], link_b.misoWire};
         link_b.sclk <= 1'b1;
         #80;
      end
      link_b.selN <= 1'b1;
      link_b.hostData <= ~link_b.hostData;
      #400;
   endtask

   initial
   begin
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 15'h0000;
      reqData = 8'h00;
      link_b.selN = 1'b1;
      link_b.sclk = 1'b1;
      link_b.hostData = 1'b0;
      miscompares = 0;
      n_checks = 0;
      void'($urandom(32'h4de7));
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      for (i = 0; i < 14; i++)
      begin
         mem[i] = 8'($urandom);
         hostAcc(1'b1, i[14:0], mem[i], q);
      end
      hostAcc(1'b1, 15'h000e, 8'hff, q);
      hostAcc(1'b1, 15'h0014, 8'hff, q);
      for (i = 0; i < 19; i++)
      begin
         a = (i < 16) ? i[14:0] : (i == 16) ? 15'h7fff : (i == 17) ? 15'h0014 : 15'h0010;
         hostAcc(1'b0, a, 8'h00, q);
         check("read", q, expRead(a));
      end
      check("reg0A", reg0A, mem[0]);
      bang({1'b1, 15'h0000, 8'h3c, 16'h0000}, 24, 0, 1'b1, got);
      check("ignored", reg0B, 8'h00);
      bang({1'b1, 15'h0000, 8'h3c, 16'h0000}, 20, 0, 1'b0, got);
      check("abort", reg0B, 8'h00);
      bang({1'b1, 15'h0000, 8'h3c, 8'hc3, 8'h00}, 32, 5000, 1'b0, got);
      check("write", reg0B, 8'h3c);
      check("wrquiet", got[15:8], 8'h00);
      check("wrquiet2", got[7:0], 8'h00);
      bang({1'b0, 15'h0000, 24'h000000}, 32, 0, 1'b0, got);
      check("rd0", got[15:8], 8'h3c);
      check("rd1", got[7:0], 8'hc3);
      final_report;
   end
endmodule
`default_nettype wire
